// ### hw/tmabi_host.sv
// Host-side controller that runs conversions on a two-mode flash converter.
// Assumes the converter pins are wired directly; tri-states resolve outside.
`timescale 1ns/1ps
`default_nettype none
module tmabi_host
    import tmabi_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // User command side.
    input wire logic start_i,
    input wire logic write_read_i,
    output logic busy_o,
    output logic result_valid_o,
    output logic [tmabi_pkg::RES_W-1:0] result_o,
    output logic timeout_o,
    // Converter pins.
    output logic cs_n_o,
    output logic rd_n_o,
    output logic mode_o,
    input wire logic wr_rdy_i,
    output logic wr_rdy_o,
    output logic wr_rdy_oe_n_o,
    input wire logic done_n_i,
    input wire logic [tmabi_pkg::RES_W-1:0] result_bus_i
);
    import tmabi_pkg::*;

    // Synchronised pin levels.
    tmabi_sync_if sync_bus ();
    logic [RES_W+1:0] sync_vec;

    // State and timer registers.
    tmabi_state_type state_q, state_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic mode_q, mode_d;
    logic cs_n_q, cs_n_d;
    logic rd_n_q, rd_n_d;
    logic wr_n_q, wr_n_d;
    logic wr_oe_n_q, wr_oe_n_d;
    logic busy_q, busy_d;
    logic valid_q, valid_d;
    logic tmo_q, tmo_d;
    logic [RES_W-1:0] res_q, res_d;

    // Pin inputs pass the three-stage filter before the sequencer sees them.
    tmabi_pin_sync #(
        .W(RES_W + 2)
    ) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .raw_i({done_n_i, wr_rdy_i, result_bus_i}),
        .sync_o(sync_vec)
    );

    assign sync_bus.done_n = sync_vec[RES_W+1];
    assign sync_bus.rdy = sync_vec[RES_W];
    assign sync_bus.data = sync_vec[RES_W-1:0];

    // Decoded conditions used by the sequencer.
    wire done_seen = !sync_bus.done_n;
    wire tmr_zero = (tmr_q == '0);
    wire [TMR_W-1:0] tmr_dec = tmr_q - 1'b1;

    // Next-state logic for the whole conversion cycle.
    always_comb
    begin
        state_d = state_q;
        tmr_d = tmr_zero ? tmr_q : tmr_dec;
        mode_d = mode_q;
        cs_n_d = cs_n_q;
        rd_n_d = rd_n_q;
        wr_n_d = wr_n_q;
        wr_oe_n_d = wr_oe_n_q;
        busy_d = busy_q;
        valid_d = 1'b0;
        tmo_d = 1'b0;
        res_d = res_q;
        unique case (state_q)
            TMABI_IDLE:
            begin
                if (start_i)
                begin
                    busy_d = 1'b1;
                    mode_d = write_read_i;
                    cs_n_d = 1'b0;
                    if (write_read_i)
                    begin
                        // Host drives the shared pin as a write strobe.
                        wr_oe_n_d = 1'b0;
                        wr_n_d = 1'b0;
                        tmr_d = TMR_W'(WR_PULSE_CYC);
                        state_d = TMABI_WRITE;
                    end
                    else
                    begin
                        // Read-only: leave the shared pin to the device's ready output.
                        wr_oe_n_d = 1'b1;
                        rd_n_d = 1'b0;
                        tmr_d = TMR_W'(READ_TMO_CYC);
                        state_d = TMABI_WAIT_DONE;
                    end
                end
            end
            TMABI_WRITE:
            begin
                // Raising the write strobe starts the conversion proper.
                if (tmr_zero)
                begin
                    wr_n_d = 1'b1;
                    tmr_d = TMR_W'(WR_TO_RD_CYC);
                    state_d = TMABI_WAIT_WR;
                end
            end
            TMABI_WAIT_WR:
            begin
                // Read may not fall until the least write-to-read delay is over.
                if (tmr_zero)
                begin
                    rd_n_d = 1'b0;
                    tmr_d = TMR_W'(INT_TMO_CYC);
                    state_d = TMABI_WAIT_DONE;
                end
            end
            TMABI_WAIT_DONE:
            begin
                // Done flag low means data is about to drive the bus.
                if (done_seen)
                begin
                    tmr_d = TMR_W'(ACC_INT_CYC);
                    state_d = TMABI_SETTLE;
                end
                else if (tmr_zero)
                begin
                    // The device missed its deadline; abandon and report.
                    tmo_d = 1'b1;
                    rd_n_d = 1'b1;
                    tmr_d = TMR_W'(RIH_CYC);
                    state_d = TMABI_RELEASE;
                end
            end
            TMABI_SETTLE:
            begin
                // Sample the bus once the access margin has passed.
                if (tmr_zero)
                begin
                    res_d = sync_bus.data;
                    valid_d = 1'b1;
                    rd_n_d = 1'b1;
                    tmr_d = TMR_W'(RIH_CYC);
                    state_d = TMABI_RELEASE;
                end
            end
            TMABI_RELEASE:
            begin
                // Wait for the flag to rise and the bus to float before deselecting.
                if (tmr_zero)
                begin
                    cs_n_d = 1'b1;
                    wr_oe_n_d = 1'b1;
                    tmr_d = TMR_W'(NEXT_CONV_CYC);
                    state_d = TMABI_GAP;
                end
            end
            TMABI_GAP:
            begin
                // Enforce the least spacing before the next conversion.
                if (tmr_zero)
                begin
                    busy_d = 1'b0;
                    state_d = TMABI_IDLE;
                end
            end
            default:
            begin
                state_d = TMABI_IDLE;
            end
        endcase
    end

    // State registers; every output comes from one of them.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_q <= TMABI_IDLE;
            tmr_q <= '0;
            mode_q <= 1'b0;
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            wr_oe_n_q <= 1'b1;
            busy_q <= 1'b0;
            valid_q <= 1'b0;
            tmo_q <= 1'b0;
            res_q <= RESULT_RST;
        end
        else
        begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            mode_q <= mode_d;
            cs_n_q <= cs_n_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            wr_oe_n_q <= wr_oe_n_d;
            busy_q <= busy_d;
            valid_q <= valid_d;
            tmo_q <= tmo_d;
            res_q <= res_d;
        end
    end

    // Outputs straight from flip-flops.
    assign busy_o = busy_q;
    assign result_valid_o = valid_q;
    assign result_o = res_q;
    assign timeout_o = tmo_q;
    assign cs_n_o = cs_n_q;
    assign rd_n_o = rd_n_q;
    assign mode_o = mode_q;
    assign wr_rdy_o = wr_n_q;
    assign wr_rdy_oe_n_o = wr_oe_n_q;
endmodule
`default_nettype wire

// ### hw/tmabi_pin_sync.sv
// Three-stage synchroniser with agreement filter for device pins.
// Assumes all inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module tmabi_pin_sync #(
    parameter int unsigned W = 10
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Raw pins.
    input wire logic [W-1:0] raw_i,
    // Filtered levels.
    output logic [W-1:0] sync_o
);
    // Three stages per bit; only the second and third feed the filter.
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] filt_q;

    // A bit changes only once stages two and three agree, which rejects glitches.
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk_i)
            begin
                if (!resetn_i)
                begin
                    s1_q[i] <= 1'b1;
                    s2_q[i] <= 1'b1;
                    s3_q[i] <= 1'b1;
                    filt_q[i] <= 1'b1;
                end
                else
                begin
                    s1_q[i] <= raw_i[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i])
                    begin
                        filt_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

    assign sync_o = filt_q;
endmodule
`default_nettype wire

// ### hw/tmabi_pkg.sv
// Package for the host-side controller of a two-mode flash converter bus.
// Assumes a 100 MHz system clock; all pin timings are converted to cycles here.
package tmabi_pkg;

    // System clock period in picoseconds.
    localparam int unsigned CLK_PERIOD_PS = 10000;

    // Pin timing figures in nanoseconds, as printed.
    localparam int unsigned T_CONV_READ_NS = 2500;
    localparam int unsigned T_ACCESS_EXTRA_NS = 50;
    localparam int unsigned T_DIS_NS = 95;
    localparam int unsigned T_RIH_NS = 225;
    localparam int unsigned T_WR_TO_RD_NS = 400;
    localparam int unsigned T_INT_MAX_NS = 1300;
    localparam int unsigned T_ACCESS_INT_NS = 50;
    localparam int unsigned T_NEXT_CONV_NS = 500;
    localparam int unsigned T_WR_PULSE_NS = 100;

    // Least times round up to whole cycles.
    localparam int unsigned WR_TO_RD_CYC = (T_WR_TO_RD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned NEXT_CONV_CYC = (T_NEXT_CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WR_PULSE_CYC = (T_WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DIS_CYC = (T_DIS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RIH_CYC = (T_RIH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Data settle after the done flag falls, waited out before sampling.
    localparam int unsigned ACC_INT_CYC = (T_ACCESS_INT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Timeout bounds: longest time the device may take, plus the access margin in read-only mode only.
    localparam int unsigned READ_TMO_CYC =
        ((T_CONV_READ_NS + T_ACCESS_EXTRA_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned INT_TMO_CYC = (T_INT_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Width of the timer counter.
    localparam int unsigned TMR_W = 12;

    // Result width.
    localparam int unsigned RES_W = 8;

    // Idle values after reset.
    localparam logic [RES_W-1:0] RESULT_RST = 8'h00;

    // Sequencer states.
    typedef enum logic [2:0] {
        TMABI_IDLE,
        TMABI_WRITE,
        TMABI_WAIT_WR,
        TMABI_WAIT_DONE,
        TMABI_SETTLE,
        TMABI_RELEASE,
        TMABI_GAP
    } tmabi_state_type;

endpackage

// ### hw/tmabi_sync_if.sv
// Interface carrying synchronised pin levels from the input stage to the sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface tmabi_sync_if;
    // Filtered done flag, active low.
    logic done_n;
    // Filtered ready level, active low means busy.
    logic rdy;
    // Filtered result bus.
    logic [7:0] data;

    // Producer side.
    modport src (output done_n, output rdy, output data);
    // Consumer side.
    modport dst (input done_n, input rdy, input data);
endinterface
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking testbench for the converter host controller.
// A converter model stands on the pins; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tmabi_pkg::*;
    // Stimulus, model settings and score counters.
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic start_i = 1'b0;
    logic write_read_i = 1'b0;
    int lvl = 0;
    int cns = 0;
    int err_count = 0;
    int compares = 0;
    // Controller outputs and pin nets.
    logic busy_o, valid_o, tmo_o, cs_n, rd_n, mode, wr_o, wr_oe_n, done_n, rdy_n, rdy_oe, wr_pin;
    logic [7:0] res_o, bus;
    // Shared pin: host strobe, else device ready, else the board pull-up.
    assign wr_pin = !wr_oe_n ? wr_o : (rdy_oe ? rdy_n : 1'b1);
    tmabi_host tmabi_host_i (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i), .write_read_i(write_read_i),
        .busy_o(busy_o), .result_valid_o(valid_o), .result_o(res_o), .timeout_o(tmo_o), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .mode_o(mode), .wr_rdy_i(wr_pin), .wr_rdy_o(wr_o), .wr_rdy_oe_n_o(wr_oe_n),
        .done_n_i(done_n), .result_bus_i(bus));
    tmabi_adc_model tmabi_adc_model_i (.cs_n_i(cs_n), .rd_n_i(rd_n), .mode_i(mode), .wr_n_i(wr_pin),
        .sample_i(lvl), .conv_ns_i(cns), .done_n_o(done_n), .rdy_n_o(rdy_n), .rdy_oe_o(rdy_oe), .data_o(bus));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    // Counts one comparison and reports a mismatch at once.
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic conclude;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Issues one request with the model set to the given level and time.
    task automatic go(input logic wr, input int l, input int c);
        @(negedge clk_i);
        lvl = l;
        cns = c;
        write_read_i = wr;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
    endtask
    // One conversion, judged on its answer; then waits out the gap.
    task automatic conv(input logic wr, input int l, input int c, input logic [7:0] exp, input logic to);
        int n;
        go(wr, l, c);
        for (n = 0; n < 600 && valid_o !== 1'b1 && tmo_o !== 1'b1; n++)
            @(negedge clk_i);
        // A wait that runs out without any answer counts as a mismatch here.
        check("answer", 8'h01, {7'h00, valid_o === 1'b1 || tmo_o === 1'b1});
        check("timeout", {7'h00, to}, {7'h00, tmo_o});
        if (!to) check("result", exp, res_o);
        for (n = 0; n < 300 && busy_o !== 1'b0; n++)
            @(negedge clk_i);
        check("busy", 8'h00, {7'h00, busy_o});
    endtask
    // Read-only mode: plain, both clamps, and the longest legal time.
    task automatic t_read;
        conv(1'b0, 165, 1600, 8'hA5, 1'b0);
        conv(1'b0, -9, 300, 8'h00, 1'b0);
        conv(1'b0, 300, 2500, 8'hFF, 1'b0);
        $display("read-only tests done");
    endtask
    // Write-read mode: done after the read, before it, and at the limit.
    task automatic t_write;
        conv(1'b1, 60, 600, 8'h3C, 1'b0);
        conv(1'b1, 255, 300, 8'hFF, 1'b0);
        conv(1'b1, 129, 1300, 8'h81, 1'b0);
        $display("write-read tests done");
    endtask
    // A second start while busy is ignored: one result, mode unchanged.
    task automatic t_refuse;
        int n;
        int nv;
        nv = 0;
        go(1'b0, 200, 1000);
        repeat (5) @(negedge clk_i);
        go(1'b1, 7, 300);
        for (n = 0; n < 600 && busy_o !== 1'b0; n++)
        begin
            @(negedge clk_i);
            if (valid_o === 1'b1) nv++;
        end
        check("valid count", 8'h01, nv[7:0]);
        check("result", 8'hC8, res_o);
        check("mode", 8'h00, {7'h00, mode});
        $display("refusal test done");
    endtask
    // A slow device must be cut short by the timeout in both modes.
    // Read-only goes first: a late flag is cleared by the next write strobe.
    task automatic t_timeout;
        conv(1'b0, 90, 3000, 8'h00, 1'b1);
        conv(1'b1, 90, 2000, 8'h00, 1'b1);
        $display("timeout test done");
    endtask
    initial
    begin
        repeat (3) @(negedge clk_i);
        resetn_i = 1'b1;
        t_read();
        t_write();
        t_refuse();
        t_timeout();
        conclude();
    end
    // Watchdog: the tests need about 2000 cycles.
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        conclude();
    end
endmodule
bind tmabi_host tmabi_host_checker tmabi_host_checker_i (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i),
    .write_read_i(write_read_i), .busy_o(busy_o), .result_valid_o(result_valid_o), .result_o(result_o),
    .timeout_o(timeout_o), .cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .mode_o(mode_o), .wr_rdy_i(wr_rdy_i),
    .wr_rdy_o(wr_rdy_o), .wr_rdy_oe_n_o(wr_rdy_oe_n_o), .done_n_i(done_n_i), .result_bus_i(result_bus_i));
`default_nettype wire

// ### testbench/tmabi_adc_model.sv
// Behavioural model of the two-mode flash converter seen from its pins.
// Clockless; its delays are nanoseconds of simulated time.
`timescale 1ns/1ps
`default_nettype none
module tmabi_adc_model (
    // Bus controls from the host.
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic mode_i,
    input wire logic wr_n_i,
    // Input level in codes and conversion time, set by the testbench.
    // Four-state integers, since a net may not carry a two-state type.
    input wire integer sample_i,
    input wire integer conv_ns_i,
    // Flag, ready and data pins.
    output logic done_n_o,
    output logic rdy_n_o,
    output logic rdy_oe_o,
    output logic [7:0] data_o
);
    // Latched result, busy state of the ready pin and done flag.
    logic [7:0] code_q = 8'h00;
    logic busy_q = 1'b0;
    logic done_q = 1'b1;
    // Converts one sample; a slow time is only set where a test wants a timeout.
    task automatic convert;
        int lvl;
        logic [3:0] hi;
        lvl = sample_i < 0 ? 0 : (sample_i > 255 ? 255 : sample_i);
        hi = 4'(lvl / 16);
        done_q = 1'b1;
        // Each caller has already waited 1 ns, so the total time is as set.
        #(conv_ns_i - 1);
        code_q = {hi, 4'(lvl - hi * 16)};
        busy_q = 1'b0;
        done_q = 1'b0;
    endtask
    // Select falling in read mode shows busy shortly after.
    // The host may move mode and select in one edge, so the pins are read 1 ns later.
    always @(negedge cs_n_i)
    begin
        #1;
        if (!mode_i) busy_q <= #49 1'b1;
    end
    // Read mode starts on read falling, write-read on write rising.
    always @(negedge rd_n_i)
    begin
        #1;
        if (!cs_n_i && !mode_i) convert();
    end
    always @(posedge wr_n_i)
    begin
        #1;
        if (!cs_n_i && mode_i) convert();
    end
    // Read rising ends the read; the flag returns high later.
    always @(posedge rd_n_i)
    begin
        if (!done_q) done_q <= #125 1'b1;
    end
    // Ready pulled low only while busy in read mode.
    assign rdy_oe_o = busy_q && !cs_n_i && !mode_i;
    assign rdy_n_o = 1'b0;
    assign done_n_o = done_q;
    // A floating bus shows inverted bits, never a stale copy.
    assign #20 data_o = (!done_q && !rd_n_i) ? code_q : ~code_q;
endmodule
`default_nettype wire

// ### testbench/tmabi_host_checker.sv
// Assertions on the converter host controller ports.
// Bound into the controller from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module tmabi_host_checker
    import tmabi_pkg::*;
(
    // Clock, reset and user side.
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic write_read_i,
    input wire logic busy_o,
    input wire logic result_valid_o,
    input wire logic [tmabi_pkg::RES_W-1:0] result_o,
    input wire logic timeout_o,
    // Converter pins.
    input wire logic cs_n_o,
    input wire logic rd_n_o,
    input wire logic mode_o,
    input wire logic wr_rdy_i,
    input wire logic wr_rdy_o,
    input wire logic wr_rdy_oe_n_o,
    input wire logic done_n_i,
    input wire logic [tmabi_pkg::RES_W-1:0] result_bus_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Saturating counts of cycles spent high on each strobe.
    logic [11:0] wr_q, rd_q, cs_q;
    function automatic logic [11:0] up(input logic hi, input logic [11:0] c);
        return !hi ? 12'h000 : c + {11'h000, c != 12'hFFF};
    endfunction
    // Counts start saturated, so the first request after reset owes no gap.
    always_ff @(posedge clk_i)
    begin
        wr_q <= resetn_i ? up(wr_rdy_o, wr_q) : 12'hFFF;
        rd_q <= resetn_i ? up(rd_n_o, rd_q) : 12'hFFF;
        cs_q <= resetn_i ? up(cs_n_o, cs_q) : 12'hFFF;
    end
    // A write strobe begins, and the read strobe stays off for its first 8 cycles.
    sequence wr_go_s;
        $fell(wr_rdy_o) && !wr_rdy_oe_n_o;
    endsequence
    sequence rd_off_s;
        rd_n_o [*8];
    endsequence
    wr_select_a:
        assert property (wr_go_s |-> !cs_n_o && mode_o) else $error("write strobe without select");
    wr_hold_a:
        assert property (wr_go_s |-> rd_off_s) else $error("read strobe during write");
    wr_to_rd_a:
        assert property ($fell(rd_n_o) && mode_o |-> wr_q >= WR_TO_RD_CYC) else $error("read too soon");
    ro_start_a:
        assert property ($fell(cs_n_o) && !mode_o |-> !rd_n_o && wr_rdy_oe_n_o) else $error("bad read start");
    pin_drive_a:
        assert property (!wr_rdy_oe_n_o |-> mode_o && !cs_n_o) else $error("shared pin driven in read mode");
    start_take_a:
        assert property (start_i && !busy_o |=> busy_o && !cs_n_o && mode_o == $past(write_read_i))
        else $error("start not taken");
    result_take_a:
        assert property (result_valid_o |-> $rose(rd_n_o) && !done_n_i && result_o == result_bus_i)
        else $error("result not from bus");
    release_a:
        assert property ($rose(cs_n_o) |-> rd_n_o && rd_q >= RIH_CYC) else $error("select released early");
    next_gap_a:
        assert property ($fell(cs_n_o) |-> cs_q >= NEXT_CONV_CYC) else $error("conversions too close");
endmodule
`default_nettype wire
